// File: rtl/ifq_top.sv
// module: interrupt flag aggregation, mask, timer and queue layout with an apb slave
//
// Function
// - base register holds address bits 8..23
// - word address is upper 23 bits
// - hdlc queue 128*(n+1) words at base+256
// - monitor queue follows the hdlc queue
// - cmd/ind queue 64*(n+1) words follows both
// - time base from fsync or master clock
// - flag register read-only, cleared by read
// - unmasked set flag drives irq high
// - hdlc flag on tx or rx hdlc event
// - cmd/ind rx flag on rx event
// - monitor rx flag on monitor rx event
// - monitor tx flag, per-channel register too
// - overload flag when a circular queue fills
// - fifo warning flags at three quarters
// - dma fifo overload flags when full
// - flag when prbs sequence recovered
// - flag when fault counter reaches 00ff
// - mask bits 0..13, reset all ones
// - mask bit n hides flag n
// - timer flag at period end unless restarted
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ifq_top
	import ifq_pkg::*;
#(
	parameter int FIFO_DEPTH = 32,
	parameter int LVL_W = $clog2(FIFO_DEPTH + 1)
) (
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins from outside the clock domain
	input wire logic fsync_pin,
	input wire logic mclk_pin,
	// event sources, same clock
	input wire logic hdlc_tx_event,
	input wire logic hdlc_rx_event,
	input wire logic cmd_ind_rx_event,
	input wire logic monitor_rx_event,
	input wire logic [15:0] tx_monitor_events,
	input wire logic [2:0] circ_queue_full,
	input wire logic [LVL_W-1:0] rx_fifo_level,
	input wire logic [LVL_W-1:0] tx_fifo_level,
	input wire logic [LVL_W-1:0] ic_fifo_level,
	input wire logic prbs_recovered,
	input wire logic [15:0] fault_count,
	// outputs
	output logic irq,
	output logic [22:0] init_block_word_addr,
	output logic [22:0] hdlc_queue_word_addr,
	output logic [22:0] monitor_queue_word_addr,
	output logic [22:0] cmd_ind_queue_word_addr,
	output logic [10:0] hdlc_queue_words,
	output logic [10:0] monitor_queue_words,
	output logic [8:0] cmd_ind_queue_words,
	output logic time_base_select
);
	// ==========================================
	// registers
	// ==========================================
	logic [15:0] segment_address_bits; // base register
	logic [15:0] qsize; // queue size register
	logic [NUM_FLAGS-1:0] flags; // interrupt flags
	logic [15:0] mask; // interrupt mask
	logic [15:0] tx_monitor_channel_flags; // per-channel tx monitor flags
	logic [15:0] timer_period; // timer period in ticks
	logic [15:0] rd_snap; // value captured in the last setup cycle, read or write
	logic [15:0] timer_cnt; // timer counter

	// ==========================================
	// apb decode
	// ==========================================
	wire setup_ph = psel & ~penable; // first cycle of a transfer
	wire access_ph = psel & penable; // completes this cycle
	wire hit_base = (paddr == ADDR_BASE);
	wire hit_qsize = (paddr == ADDR_QSIZE);
	wire hit_flags = (paddr == ADDR_FLAGS);
	wire hit_mask = (paddr == ADDR_MASK);
	wire hit_txmon = (paddr == ADDR_TXMON);
	wire hit_tper = (paddr == ADDR_TPER);
	wire hit_tctl = (paddr == ADDR_TCTL);
	wire hit_any = hit_base | hit_qsize | hit_flags | hit_mask | hit_txmon
		| hit_tper | hit_tctl;
	wire wr_en = access_ph & pwrite & hit_any;
	wire rd_flags = access_ph & ~pwrite & hit_flags; // clear-on-read
	wire rd_txmon = access_ph & ~pwrite & hit_txmon; // clear-on-read
	wire timer_restart = wr_en & hit_tctl & pwdata[0]; // restart strobe

	// no wait states; error on unmapped addresses
	assign pready = 1'b1;
	assign pslverr = access_ph & ~hit_any;

	// read mux, sampled in the setup cycle so data comes from a flop
	logic [15:0] next_rd;
	always_comb begin
		case (1'b1)
			hit_base: next_rd = segment_address_bits;
			hit_qsize: next_rd = qsize;
			hit_flags: next_rd = {{(16-NUM_FLAGS){1'b0}}, flags};
			hit_mask: next_rd = mask;
			hit_txmon: next_rd = tx_monitor_channel_flags;
			hit_tper: next_rd = timer_period;
			default: next_rd = 16'h0000; // restart register reads zero
		endcase
	end

	// snapshot of the read value; the later clear only drops bits in it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_snap <= 16'h0000;
		end else if (setup_ph) begin
			rd_snap <= next_rd;
		end
	end
	assign prdata = {16'h0000, rd_snap};

	// ==========================================
	// writable registers
	// ==========================================
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			segment_address_bits <= RST_BASE;
			qsize <= RST_QSIZE;
			mask <= RST_MASK;
			timer_period <= RST_TPER;
		end else if (wr_en) begin
			if (hit_base) begin
				segment_address_bits <= pwdata[15:0];
			end
			if (hit_qsize) begin
				qsize <= pwdata[15:0] & QSIZE_WMASK;
			end
			if (hit_mask) begin
				mask <= pwdata[15:0];
			end
			if (hit_tper) begin
				timer_period <= pwdata[15:0];
			end
		end
	end

	// ==========================================
	// pin synchronisers and time base
	// ==========================================
	logic [1:0] fs_sync; // fsync two-flop chain
	logic [1:0] mc_sync; // master clock two-flop chain
	logic fs_d; // delayed synced fsync
	logic mc_d; // delayed synced master clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fs_sync <= 2'b00;
			mc_sync <= 2'b00;
			fs_d <= 1'b0;
			mc_d <= 1'b0;
		end else begin
			fs_sync <= {fs_sync[0], fsync_pin};
			mc_sync <= {mc_sync[0], mclk_pin};
			fs_d <= fs_sync[1];
			mc_d <= mc_sync[1];
		end
	end
	wire fs_rise = fs_sync[1] & ~fs_d;
	wire mc_rise = mc_sync[1] & ~mc_d;
	assign time_base_select = qsize[POS_TBSEL];
	// the master clock must stay below half of clk to be seen edge by edge
	wire tick = time_base_select ? fs_rise : mc_rise;

	// ==========================================
	// timer
	// ==========================================
	// a period of zero is treated as one tick so the flag cannot stick
	wire timer_end = tick & (timer_cnt + 16'h0001 >= timer_period);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_cnt <= 16'h0000;
		end else if (timer_restart) begin
			timer_cnt <= 16'h0000; // restart wins over a tick
		end else if (timer_end) begin
			timer_cnt <= 16'h0000;
		end else if (tick) begin
			timer_cnt <= timer_cnt + 16'h0001;
		end
	end
	wire timer_evt = timer_end & ~timer_restart;

	// ==========================================
	// fifo level watchers
	// ==========================================
	localparam logic [LVL_W-1:0] WARN_LVL = LVL_W'((FIFO_DEPTH * 3 + 3) / 4);
	localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(FIFO_DEPTH);
	logic [LVL_W-1:0] fifo_lvl [3];
	assign fifo_lvl[0] = rx_fifo_level;
	assign fifo_lvl[1] = tx_fifo_level;
	assign fifo_lvl[2] = ic_fifo_level;
	logic [2:0] warn_evt; // rising into three-quarter level
	logic [2:0] ovl_evt; // rising into full
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_fifo
			logic warn_d; // previous warning level
			logic full_d; // previous full level
			wire warn_now = (fifo_lvl[gi] >= WARN_LVL);
			wire full_now = (fifo_lvl[gi] >= FULL_LVL);
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					warn_d <= 1'b0;
					full_d <= 1'b0;
				end else begin
					warn_d <= warn_now;
					full_d <= full_now;
				end
			end
			assign warn_evt[gi] = warn_now & ~warn_d;
			assign ovl_evt[gi] = full_now & ~full_d;
		end
	endgenerate

	// ==========================================
	// other event detectors
	// ==========================================
	logic [2:0] cq_d; // previous circular queue full levels
	logic fault_hit_d; // previous limit match
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cq_d <= 3'b000;
			fault_hit_d <= 1'b0;
		end else begin
			cq_d <= circ_queue_full;
			fault_hit_d <= (fault_count == FAULT_LIMIT);
		end
	end
	wire cq_evt = |(circ_queue_full & ~cq_d);
	wire fault_evt = (fault_count == FAULT_LIMIT) & ~fault_hit_d;

	// ==========================================
	// flag set vector
	// ==========================================
	logic [NUM_FLAGS-1:0] set_vec;
	always_comb begin
		set_vec = '0;
		set_vec[F_HDLC] = hdlc_tx_event | hdlc_rx_event;
		set_vec[F_CIRX] = cmd_ind_rx_event;
		set_vec[F_MRX] = monitor_rx_event;
		set_vec[F_MTX] = |tx_monitor_events;
		set_vec[F_CQOV] = cq_evt;
		set_vec[F_FIFO0] = warn_evt[0];
		set_vec[F_FIFO0+1] = ovl_evt[0];
		set_vec[F_FIFO0+2] = warn_evt[1];
		set_vec[F_FIFO0+3] = ovl_evt[1];
		set_vec[F_FIFO0+4] = warn_evt[2];
		set_vec[F_FIFO0+5] = ovl_evt[2];
		set_vec[F_TIM] = timer_evt;
		set_vec[F_PRBS_RECOVERED_FLAG] = prbs_recovered;
		set_vec[F_FAULT_COUNTER_OVERLOAD_FLAG] = fault_evt;
	end

	// ==========================================
	// flag registers, clear-on-read, set wins
	// ==========================================
	// only the bits handed out are cleared, so an event that lands
	// between setup and access is kept for the next read
	wire [NUM_FLAGS-1:0] flag_clr = rd_flags ? rd_snap[NUM_FLAGS-1:0] : '0;
	wire [15:0] txmon_clr = rd_txmon ? rd_snap : 16'h0000;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags <= RST_FLAGS[NUM_FLAGS-1:0];
			tx_monitor_channel_flags <= 16'h0000;
		end else begin
			flags <= set_vec | (flags & ~flag_clr);
			tx_monitor_channel_flags <= tx_monitor_events
				| (tx_monitor_channel_flags & ~txmon_clr);
		end
	end

	// ==========================================
	// interrupt output
	// ==========================================
	// registered so the pin is glitch free; follows flags by one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags & ~mask[NUM_FLAGS-1:0]);
		end
	end

	// ==========================================
	// queue layout
	// ==========================================
	wire [2:0] hs = qsize[POS_HDLC +: 3];
	wire [2:0] ms = qsize[POS_MON +: 3];
	wire [1:0] cs = qsize[POS_CMD +: 2];
	wire [10:0] next_hdlc_words = 11'({1'b0, hs} + 4'h1) << HDLC_Q_STEP_SH;
	wire [10:0] next_mon_words = 11'({1'b0, ms} + 4'h1) << HDLC_Q_STEP_SH;
	wire [8:0] next_cmd_words = 9'({1'b0, cs} + 3'h1) << CMD_Q_STEP_SH;
	// byte addresses; low byte of the base is always zero
	wire [23:0] init_block_base_address = {segment_address_bits, 8'h00};
	wire [23:0] hdlc_b = init_block_base_address + QUEUE_AREA_OFS;
	wire [23:0] mon_b = hdlc_b + {12'h000, next_hdlc_words, 1'b0};
	wire [23:0] cmd_b = mon_b + {12'h000, next_mon_words, 1'b0};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_block_word_addr <= '0;
			hdlc_queue_word_addr <= '0;
			monitor_queue_word_addr <= '0;
			cmd_ind_queue_word_addr <= '0;
			hdlc_queue_words <= '0;
			monitor_queue_words <= '0;
			cmd_ind_queue_words <= '0;
		end else begin
			init_block_word_addr <= init_block_base_address[23:1];
			hdlc_queue_word_addr <= hdlc_b[23:1];
			monitor_queue_word_addr <= mon_b[23:1];
			cmd_ind_queue_word_addr <= cmd_b[23:1];
			hdlc_queue_words <= next_hdlc_words;
			monitor_queue_words <= next_mon_words;
			cmd_ind_queue_words <= next_cmd_words;
		end
	end
endmodule : ifq_top
`default_nettype wire

// File: rtl/ifq_pkg.sv
// package: register map, field layout and reset values of the flag/queue block
package ifq_pkg;
	// ==========================================
	// register indices and byte addresses
	// ==========================================
	localparam logic [11:0] IDX_BASE = 12'h034; // init block base
	localparam logic [11:0] IDX_QSIZE = 12'h036; // queue sizes
	localparam logic [11:0] IDX_FLAGS = 12'h038; // interrupt flags
	localparam logic [11:0] IDX_MASK = 12'h03a; // interrupt mask
	localparam logic [11:0] IDX_TXMON = 12'h030; // tx monitor channel flags
	localparam logic [11:0] IDX_TPER = 12'h03c; // timer period
	localparam logic [11:0] IDX_TCTL = 12'h040; // timer restart
	localparam logic [11:0] ADDR_BASE = 12'h0d0;
	localparam logic [11:0] ADDR_QSIZE = 12'h0d8;
	localparam logic [11:0] ADDR_FLAGS = 12'h0e0;
	localparam logic [11:0] ADDR_MASK = 12'h0e8;
	localparam logic [11:0] ADDR_TXMON = 12'h0c0;
	localparam logic [11:0] ADDR_TPER = 12'h0f0;
	localparam logic [11:0] ADDR_TCTL = 12'h100;
	// ==========================================
	// reset values
	// ==========================================
	localparam logic [15:0] RST_BASE = 16'h0000;
	localparam logic [15:0] RST_QSIZE = 16'h0000;
	localparam logic [15:0] RST_FLAGS = 16'h0000;
	localparam logic [15:0] RST_MASK = 16'hffff;
	localparam logic [15:0] RST_TPER = 16'h0200;
	// ==========================================
	// field positions of the queue size register
	// ==========================================
	localparam int POS_CMD = 0; // 2 bits
	localparam int POS_MON = 2; // 3 bits
	localparam int POS_HDLC = 5; // 3 bits
	localparam int POS_TBSEL = 15;
	localparam logic [15:0] QSIZE_WMASK = 16'h80ff; // writable bits
	// ==========================================
	// flag bit positions
	// ==========================================
	localparam int NUM_FLAGS = 14;
	localparam int F_HDLC = 0;
	localparam int F_CIRX = 1;
	localparam int F_MRX = 2;
	localparam int F_MTX = 3;
	localparam int F_CQOV = 4;
	localparam int F_FIFO0 = 5; // warn/overload pairs: rx dma, tx dma, int ctrl
	localparam int F_TIM = 11;
	localparam int F_PRBS_RECOVERED_FLAG = 12;
	localparam int F_FAULT_COUNTER_OVERLOAD_FLAG = 13;
	// ==========================================
	// queue geometry
	// ==========================================
	localparam int HDLC_Q_STEP_SH = 7; // 128 words per step
	localparam int CMD_Q_STEP_SH = 6; // 64 words per step
	localparam logic [23:0] QUEUE_AREA_OFS = 24'h000100; // 256 bytes
	localparam logic [15:0] FAULT_LIMIT = 16'h00ff;
endpackage : ifq_pkg

// File: tb/ifq_top_properties.sv
// checker: port-level properties of the flag and queue block
`timescale 1ns/100ps
`default_nettype none
module ifq_checker
	import ifq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic hdlc_tx_event,
	input wire logic hdlc_rx_event,
	input wire logic prbs_recovered,
	input wire logic [15:0] fault_count,
	input wire logic irq,
	input wire logic [22:0] init_block_word_addr,
	input wire logic [22:0] hdlc_queue_word_addr,
	input wire logic [22:0] monitor_queue_word_addr,
	input wire logic [22:0] cmd_ind_queue_word_addr,
	input wire logic [10:0] hdlc_queue_words,
	input wire logic [10:0] monitor_queue_words,
	input wire logic time_base_select
);
	// ==========================================
	// shadow copies of the written registers
	// ==========================================
	wire wr_acc = psel & penable & pwrite; // write access edge
	wire base_wr = wr_acc && paddr == ADDR_BASE;
	wire qs_wr = wr_acc && paddr == ADDR_QSIZE;
	wire mask_wr = wr_acc && paddr == ADDR_MASK;
	wire mapped = paddr inside {ADDR_BASE, ADDR_QSIZE, ADDR_FLAGS, ADDR_MASK, ADDR_TXMON,
		ADDR_TPER, ADDR_TCTL};
	logic [15:0] mask_sh, base_sh, qs_sh;
	// shadows follow writes only; reads never disturb them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_sh <= RST_MASK;
			base_sh <= RST_BASE;
			qs_sh <= RST_QSIZE;
		end else begin
			if (mask_wr) mask_sh <= pwdata[15:0];
			if (base_wr) base_sh <= pwdata[15:0];
			if (qs_wr) qs_sh <= pwdata[15:0] & QSIZE_WMASK;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	err_map_a: assert property (psel && penable |-> pslverr == !mapped)
		else $error("error response does not match the address map");
	base_addr_a: assert property (base_wr |-> ##[1:2] init_block_word_addr == {base_sh, 7'h00})
		else $error("init block word address wrong");
	hdlc_size_a: assert property (qs_wr |-> ##[1:2]
		hdlc_queue_words == ({8'h00, qs_sh[7:5]} + 11'h001) << 7)
		else $error("hdlc queue size wrong");
	// registered layout outputs are still at their reset zeros on the first edge after release
	hdlc_place_a: assert property ($past(rst_n) |->
		hdlc_queue_word_addr == init_block_word_addr + 23'h000080)
		else $error("hdlc queue not 256 bytes above base");
	mon_place_a: assert property (
		monitor_queue_word_addr == hdlc_queue_word_addr + 23'(hdlc_queue_words))
		else $error("monitor queue not after hdlc queue");
	cmd_place_a: assert property (
		cmd_ind_queue_word_addr == monitor_queue_word_addr + 23'(monitor_queue_words))
		else $error("cmd/ind queue not after monitor queue");
	tbsel_a: assert property (qs_wr |=> time_base_select == qs_sh[15])
		else $error("time base select not taken");
	hdlc_irq_a: assert property ((hdlc_rx_event || hdlc_tx_event) && !mask_sh[F_HDLC] && !mask_wr
		|-> ##2 irq)
		else $error("hdlc event did not raise irq");
	prbs_irq_a: assert property (prbs_recovered && !mask_sh[F_PRBS_RECOVERED_FLAG] && !mask_wr |-> ##2 irq)
		else $error("prbs event did not raise irq");
	fault_irq_a: assert property (fault_count == FAULT_LIMIT && $past(fault_count) != FAULT_LIMIT
		&& !mask_sh[F_FAULT_COUNTER_OVERLOAD_FLAG] && !mask_wr |-> ##2 irq)
		else $error("fault limit did not raise irq");
	masked_quiet_a: assert property (mask_wr && pwdata[13:0] == 14'h3fff |-> ##2 !irq)
		else $error("irq high with all sources masked");
endmodule : ifq_checker
bind ifq_top ifq_checker u_ifq_checker (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
	.hdlc_tx_event(hdlc_tx_event), .hdlc_rx_event(hdlc_rx_event),
	.prbs_recovered(prbs_recovered), .fault_count(fault_count), .irq(irq),
	.init_block_word_addr(init_block_word_addr), .hdlc_queue_word_addr(hdlc_queue_word_addr),
	.monitor_queue_word_addr(monitor_queue_word_addr),
	.cmd_ind_queue_word_addr(cmd_ind_queue_word_addr), .hdlc_queue_words(hdlc_queue_words),
	.monitor_queue_words(monitor_queue_words), .time_base_select(time_base_select));
`default_nettype wire

// File: tb/ifq_source_model.sv
// partner model: event sources and time base pins facing the flag block
`timescale 1ns/100ps
`default_nettype none
module ifq_source_model #(
	parameter int LVL_W = 6,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	output logic hdlc_tx_event,
	output logic hdlc_rx_event,
	output logic cmd_ind_rx_event,
	output logic monitor_rx_event,
	output logic [15:0] tx_monitor_events,
	output logic [2:0] circ_queue_full,
	output logic [LVL_W-1:0] rx_fifo_level,
	output logic [LVL_W-1:0] tx_fifo_level,
	output logic [LVL_W-1:0] ic_fifo_level,
	output logic prbs_recovered,
	output logic [15:0] fault_count,
	output logic fsync_pin,
	output logic mclk_pin
);
	// three quarters of the fifo, rounded up
	localparam logic [LVL_W-1:0] WARN = LVL_W'((3 * DEPTH + 3) / 4);
	localparam logic [LVL_W-1:0] FULL = LVL_W'(DEPTH);
	// every source back to its quiet level
	task automatic idle();
		{hdlc_tx_event, hdlc_rx_event, cmd_ind_rx_event, monitor_rx_event, prbs_recovered,
			tx_monitor_events, circ_queue_full, rx_fifo_level, tx_fifo_level, ic_fifo_level,
			fault_count} <= '0;
	endtask : idle
	initial begin
		idle();
		fsync_pin <= 1'b0;
		mclk_pin <= 1'b0;
	end
	// one-cycle event, indexed by the flag bit it should set (14: hdlc tx)
	task automatic pulse(input int k);
		case (k)
			0: hdlc_rx_event <= 1'b1;
			1: cmd_ind_rx_event <= 1'b1;
			2: monitor_rx_event <= 1'b1;
			3: tx_monitor_events <= 16'h0020;
			4: circ_queue_full <= 3'h2;
			5: rx_fifo_level <= WARN;
			6: rx_fifo_level <= FULL;
			7: tx_fifo_level <= WARN;
			8: tx_fifo_level <= FULL;
			9: ic_fifo_level <= WARN;
			10: ic_fifo_level <= FULL;
			12: prbs_recovered <= 1'b1;
			13: fault_count <= 16'h00ff;
			default: hdlc_tx_event <= 1'b1;
		endcase
		@(posedge clk);
		idle();
	endtask : pulse
	// slow rising edges on one time base pin; held long enough for the synchroniser
	task automatic tick(input logic fs, input int n);
		repeat (n) begin
			if (fs) fsync_pin <= 1'b1;
			else mclk_pin <= 1'b1;
			repeat (4) @(posedge clk);
			fsync_pin <= 1'b0;
			mclk_pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask : tick
endmodule : ifq_source_model
`default_nettype wire

// File: tb/ifq_top_bench.sv
// testbench: register, event and timer sequences for the flag block
`timescale 1ns/100ps
`default_nettype none
module ifq_top_bench;
	import ifq_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, tbs, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [22:0] ia, ha, ma, ca;
	logic [10:0] hw, mw;
	logic [8:0] cw;
	wire hdlc_tx_event, hdlc_rx_event, cmd_ind_rx_event, monitor_rx_event, prbs_recovered;
	wire fsync_pin, mclk_pin;
	wire [15:0] tx_monitor_events, fault_count;
	wire [2:0] circ_queue_full;
	wire [5:0] rx_fifo_level, tx_fifo_level, ic_fifo_level;
	int err_total, checks;
	int ev[14] = '{0, 14, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 12, 13};
	ifq_top #(.FIFO_DEPTH(32)) u_ifq_top (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fsync_pin(fsync_pin), .mclk_pin(mclk_pin),
		.hdlc_tx_event(hdlc_tx_event), .hdlc_rx_event(hdlc_rx_event),
		.cmd_ind_rx_event(cmd_ind_rx_event), .monitor_rx_event(monitor_rx_event),
		.tx_monitor_events(tx_monitor_events), .circ_queue_full(circ_queue_full),
		.rx_fifo_level(rx_fifo_level), .tx_fifo_level(tx_fifo_level),
		.ic_fifo_level(ic_fifo_level), .prbs_recovered(prbs_recovered), .fault_count(fault_count),
		.irq(irq), .init_block_word_addr(ia), .hdlc_queue_word_addr(ha),
		.monitor_queue_word_addr(ma), .cmd_ind_queue_word_addr(ca), .hdlc_queue_words(hw),
		.monitor_queue_words(mw), .cmd_ind_queue_words(cw), .time_base_select(tbs));
	ifq_source_model #(.LVL_W(6), .DEPTH(32)) u_src (.clk(clk), .hdlc_tx_event(hdlc_tx_event),
		.hdlc_rx_event(hdlc_rx_event), .cmd_ind_rx_event(cmd_ind_rx_event),
		.monitor_rx_event(monitor_rx_event), .tx_monitor_events(tx_monitor_events),
		.circ_queue_full(circ_queue_full), .rx_fifo_level(rx_fifo_level),
		.tx_fifo_level(tx_fifo_level), .ic_fifo_level(ic_fifo_level),
		.prbs_recovered(prbs_recovered), .fault_count(fault_count), .fsync_pin(fsync_pin),
		.mclk_pin(mclk_pin));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	// one apb transfer, held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			finish_test();
		end else begin
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, x, q);
	endtask : rd
	// flag bits expected from one source event (overload also crosses the warning level)
	function automatic logic [31:0] flag_of(input int k);
		if (k == 14) return 32'h1;
		if (k == 6 || k == 8 || k == 10) return 32'h3 << (k - 1);
		return 32'h1 << k;
	endfunction : flag_of
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		finish_test();
	end
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, err_total, checks} = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		chk("hq_words", 32'h80, hw);
		rd(ADDR_BASE, 32'h0, "base");
		rd(ADDR_QSIZE, 32'h0, "qsize");
		rd(ADDR_FLAGS, 32'h0, "flags");
		rd(ADDR_MASK, 32'hffff, "mask");
		apb(1'b0, 12'h0fc, 32'h0);
		chk("unmapped_err", 32'h1, e);
		$display("test reset done");
		wr(ADDR_BASE, 32'h1234);
		wr(ADDR_QSIZE, 32'hffff);
		rd(ADDR_QSIZE, 32'h80ff, "qsize_rb");
		chk("init_addr", 32'h91a00, ia);
		chk("hq_addr", 32'h91a80, ha);
		chk("mq_addr", 32'h91e80, ma);
		chk("cq_addr", 32'h92280, ca);
		chk("mq_words", 32'h400, mw);
		chk("cq_words", 32'h100, cw);
		chk("tbsel", 32'h1, tbs);
		wr(ADDR_QSIZE, 32'h0006);
		// sizes are registered one edge after the write lands
		@(posedge clk);
		chk("cq_words_2", 32'hc0, cw);
		chk("mq_words_2", 32'h100, mw);
		$display("test layout done");
		wr(ADDR_MASK, 32'h0);
		foreach (ev[i]) begin
			u_src.pulse(ev[i]);
			repeat (2) @(posedge clk);
			chk("irq_set", 32'h1, irq);
			rd(ADDR_FLAGS, flag_of(ev[i]), "flags_ev");
			rd(ADDR_FLAGS, 32'h0, "flags_clr");
			chk("irq_low", 32'h0, irq);
			if (ev[i] == 3) rd(ADDR_TXMON, 32'h0020, "txmon");
		end
		$display("test events done");
		wr(ADDR_MASK, 32'h1);
		u_src.pulse(0);
		repeat (2) @(posedge clk);
		chk("irq_masked", 32'h0, irq);
		wr(ADDR_MASK, 32'h0);
		@(posedge clk);
		chk("irq_unmasked", 32'h1, irq);
		wr(ADDR_MASK, 32'h3fff);
		@(posedge clk);
		chk("irq_remask", 32'h0, irq);
		wr(ADDR_FLAGS, 32'hffff);
		rd(ADDR_FLAGS, 32'h1, "flags_ro");
		$display("test mask done");
		wr(ADDR_TPER, 32'h3);
		wr(ADDR_QSIZE, 32'h0);
		wr(ADDR_TCTL, 32'h1);
		u_src.tick(1'b0, 3);
		rd(ADDR_FLAGS, 32'h800, "tim_mclk");
		wr(ADDR_TCTL, 32'h1);
		u_src.tick(1'b0, 2);
		wr(ADDR_TCTL, 32'h1);
		u_src.tick(1'b0, 2);
		rd(ADDR_FLAGS, 32'h0, "tim_restart");
		wr(ADDR_QSIZE, 32'h8000);
		wr(ADDR_TCTL, 32'h1);
		u_src.tick(1'b0, 3);
		rd(ADDR_FLAGS, 32'h0, "tim_mclk_off");
		u_src.tick(1'b1, 3);
		rd(ADDR_FLAGS, 32'h800, "tim_fsync");
		$display("test timer done");
		finish_test();
	end
endmodule : ifq_top_bench
`default_nettype wire
